// [sspsl_pkg.sv]
// Behaviour
// R1 - When enabled, wait for START, then shift the next 8 bits in.
// R2 - Sample every data bit on the rising edge of SCL.
// R3 - On the 8th SCL falling edge compare shift bits 7:1 with own address.
// R4 - Match with both flags clear loads the buffer and sets buffer-full.
// R5 - Match with both flags clear drives an acknowledge on SDA.
// R6 - Accepted address sets the interrupt flag; interrupt only if enabled.
// R7 - 10-bit mode recognises the first byte by its 11110 high bits.
// R8 - Master sends the 10-bit high byte with write direction.
// R9 - After the high byte set flags and update-address, hold SCL low.
// R10 - After the low byte set flags and update-address again, same release.
// R11 - Reading the buffer clears buffer-full; interrupt flag stays until cleared.
// R12 - After repeated START in 10-bit mode only the high byte is matched.
// R13 - Matched address with write direction clears the read/write status.
// R14 - No acknowledge while buffer-full or receive-overflow is set.
// R15 - Every data byte sets the interrupt flag regardless of the flags.
// R16 - Buffer-full blocks load and acknowledge; overflow alone blocks acknowledge.
// R17 - Software clears overflow before the next byte or it is not acknowledged.
// R18 - A byte completing while buffer-full is set sets receive-overflow.
// R19 - No match leaves SDA released and ignores the bus until next START.
package sspsl_pkg;
  localparam int SSPSL_BYTE_W = 8;
  localparam int SSPSL_FIFO_D = 8;
  localparam logic [3:0] SSPSL_ACK_BIT = 4'h8;
  localparam logic [4:0] SSPSL_TEN_HDR = 5'h1e;
  localparam int SSPSL_HDR_LSB = 3;
  localparam int SSPSL_RW_BIT = 0;
  localparam logic [7:0] SSPSL_OWN_RST = 8'h00;

  typedef enum logic [3:0] {
    SSPSL_ADR1 = 4'h1,
    SSPSL_ADR2 = 4'h2,
    SSPSL_DATA = 4'h4,
    SSPSL_SKIP = 4'h8
  } sspsl_phase_t;

  typedef struct packed {
    logic [7:0] data;
    logic load;
    logic blk;
    logic ua;
    logic adr;
    logic rw;
  } sspsl_ev_t;

  typedef struct packed {
    logic bf;
    logic ov;
    logic ua;
    logic rw;
    logic pif;
  } sspsl_stat_t;
endpackage

// [sspsl_slave.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Receive FIFO.
// ----------------------------------------
module sspsl_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = cnt_r != (AW+1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= push ? wp_r + 1'b1 : wp_r;
      rp_r <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Slave address match and byte reception.
// ----------------------------------------
module sspsl_slave
  import sspsl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic port_enable,
  input wire logic ten_bit_mode,
  input wire logic int_enable,
  input wire logic addr_wr,
  input wire logic [7:0] addr_wdata,
  output logic [7:0] own_address_register,
  input wire logic if_clear,
  input wire logic ov_clear,
  output sspsl_stat_t status,
  output logic irq,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);

  function automatic logic hi_match(
    input logic [7:0] sh,
    input logic [7:0] own
  );
    hi_match = sh[7:1] == own[7:1];
  endfunction

  // ----------------------------------------
  // Bus pin sampling in the system domain.
  // ----------------------------------------
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;
  logic frame_r;
  logic clr_r;
  logic hold_r;

  wire start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_det = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire start_go = start_det & port_enable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // A START arms the frame and holds the link logic cleared until SCL
  // goes low, so the first data bit always meets a fresh counter.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_r <= 1'b0;
      clr_r <= 1'b0;
    end
    else
    begin
      frame_r <= start_go | (frame_r & ~stop_det & port_enable); // see R1
      clr_r <= start_go | (clr_r & scl_s_r); // see R1
    end
  end

  // ----------------------------------------
  // Link domain, clocked by SCL.
  // ----------------------------------------
  wire link_rst_n = reset_n & ~clr_r;
  logic blk_m_r;
  logic blk_s_r;
  logic ov_m_r;
  logic ov_s_r;
  logic ten_m_r;
  logic ten_s_r;
  logic [7:0] own_m_r;
  logic [7:0] own_s_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  sspsl_phase_t ph_r;
  sspsl_phase_t ph_nxt;
  logic ack_r;
  logic ten_done_r;
  logic ten_done_nxt;
  logic tg_r;
  sspsl_ev_t ev_r;
  logic bf_r;
  logic ov_r;
  logic [7:0] own_r;
  logic fifo_in_ready;

  // Flags seen by the link; the buffer also counts as full when the
  // FIFO has no room, so back-pressure reaches the bus as a NACK.
  wire blk_src = bf_r | ~fifo_in_ready;

  always_ff @(posedge scl_i or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blk_m_r <= 1'b0;
      blk_s_r <= 1'b0;
      ov_m_r <= 1'b0;
      ov_s_r <= 1'b0;
      ten_m_r <= 1'b0;
      ten_s_r <= 1'b0;
      own_m_r <= SSPSL_OWN_RST;
      own_s_r <= SSPSL_OWN_RST;
    end
    else
    begin
      blk_m_r <= blk_src;
      blk_s_r <= blk_m_r;
      ov_m_r <= ov_r;
      ov_s_r <= ov_m_r;
      ten_m_r <= ten_bit_mode;
      ten_s_r <= ten_m_r;
      own_m_r <= own_r;
      own_s_r <= own_m_r;
    end
  end

  wire shifting = cnt_r < SSPSL_ACK_BIT;

  always_ff @(posedge scl_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cnt_r <= '0;
      sh_r <= '0;
    end
    else
    begin
      cnt_r <= shifting ? cnt_r + 4'h1 : 4'h0;
      if (shifting)
      begin
        sh_r <= {sh_r[6:0], sda_i}; // see R2
      end
    end
  end

  // Decision made at the falling edge that ends the eighth bit.
  wire byte_end = cnt_r == SSPSL_ACK_BIT;
  wire hdr_ok = sh_r[7:SSPSL_HDR_LSB] == SSPSL_TEN_HDR; // see R7
  wire hi_ok = hi_match(sh_r, own_s_r); // see R3
  wire m7 = ~ten_s_r & hi_ok;
  wire m10h = ten_s_r & hdr_ok & hi_ok;
  wire rd_dir = sh_r[SSPSL_RW_BIT];
  wire m10l = sh_r == own_s_r;
  wire rep10 = m10h & ten_done_r; // see R12
  wire go_hi = m10h & ~rep10 & ~rd_dir; // see R8
  logic go;
  logic adr;
  logic ua;

  always_comb
  begin
    ph_nxt = ph_r;
    ten_done_nxt = ten_done_r;
    go = 1'b0;
    adr = 1'b0;
    ua = 1'b0;
    case (ph_r)
      SSPSL_ADR1:
      begin
        adr = 1'b1;
        if (m7 | rep10)
        begin
          go = 1'b1;
          ph_nxt = SSPSL_DATA;
        end
        else if (go_hi)
        begin
          go = 1'b1;
          ua = 1'b1; // see R9
          ph_nxt = SSPSL_ADR2;
        end
        else
        begin
          ten_done_nxt = 1'b0;
          ph_nxt = SSPSL_SKIP; // see R19
        end
      end
      SSPSL_ADR2:
      begin
        // The low address byte ends in an address bit, not a direction bit,
        // so it leaves the direction status alone.
        if (m10l)
        begin
          go = 1'b1;
          ua = 1'b1; // see R10
          ten_done_nxt = 1'b1;
          ph_nxt = SSPSL_DATA;
        end
        else
        begin
          ph_nxt = SSPSL_SKIP; // see R19
        end
      end
      SSPSL_DATA:
      begin
        go = 1'b1; // see R15
      end
      SSPSL_SKIP:
      begin
        go = 1'b0;
      end
      default:
      begin
        ph_nxt = SSPSL_SKIP;
      end
    endcase
  end

  wire ack_go = go & ~blk_s_r & ~ov_s_r; // see R5 R14 R16
  wire load_go = go & ~blk_s_r; // see R4 R16

  always_ff @(negedge scl_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      ph_r <= SSPSL_ADR1;
      ack_r <= 1'b0;
    end
    else if (byte_end)
    begin
      ph_r <= ph_nxt;
      ack_r <= ack_go;
    end
    else
    begin
      ack_r <= 1'b0;
    end
  end

  // Event word and its toggle survive a START so none is lost.
  always_ff @(negedge scl_i or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ten_done_r <= 1'b0;
      tg_r <= 1'b0;
      ev_r <= '0;
    end
    else if (byte_end)
    begin
      ten_done_r <= ten_done_nxt;
      if (go)
      begin
        tg_r <= ~tg_r;
        ev_r <= '{data: sh_r, load: load_go, blk: blk_s_r,
                  ua: ua, adr: adr, rw: rd_dir};
      end
    end
  end

  // ----------------------------------------
  // Event crossing and flags.
  // ----------------------------------------
  logic tg_m_r;
  logic tg_s_r;
  logic tg_d_r;
  logic ua_r;
  logic rw_r;
  logic pif_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tg_m_r <= 1'b0;
      tg_s_r <= 1'b0;
      tg_d_r <= 1'b0;
    end
    else
    begin
      tg_m_r <= tg_r;
      tg_s_r <= tg_m_r;
      tg_d_r <= tg_s_r;
    end
  end

  wire act = (tg_s_r ^ tg_d_r) & frame_r;
  wire push = act & ev_r.load;
  wire pop = rx_valid & rx_ready;
  wire ov_set = act & ev_r.blk;
  wire ua_set = act & ev_r.ua;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bf_r <= 1'b0;
      ov_r <= 1'b0;
      ua_r <= 1'b0;
      rw_r <= 1'b0;
      pif_r <= 1'b0;
      own_r <= SSPSL_OWN_RST;
      hold_r <= 1'b0;
    end
    else
    begin
      bf_r <= push | (bf_r & ~pop); // see R4 R11
      ov_r <= ov_set | (ov_r & ~ov_clear); // see R18
      ua_r <= ua_set | (ua_r & ~addr_wr); // see R9 R10
      pif_r <= act | (pif_r & ~if_clear); // see R6 R11 R15
      if (act & ev_r.adr)
      begin
        rw_r <= ev_r.rw; // see R13
      end
      if (addr_wr)
      begin
        own_r <= addr_wdata;
      end
      hold_r <= ua_r & ~addr_wr & (hold_r | ~scl_s_r); // see R9
    end
  end

  // ----------------------------------------
  // Buffer and outputs.
  // ----------------------------------------
  sspsl_fifo #(
    .W(SSPSL_BYTE_W),
    .D(SSPSL_FIFO_D)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(ev_r.data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = hold_r;
  assign sda_oe = ack_r & frame_r; // see R5 R19
  assign own_address_register = own_r;
  assign irq = pif_r & int_enable; // see R6
  assign status = '{bf: bf_r, ov: ov_r, ua: ua_r, rw: rw_r, pif: pif_r};

endmodule

`default_nettype wire

// [sspsl_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus master model.
// ----------------------------------------
module sspsl_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_lo,
  output logic sda_lo
);
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // Serves as START and repeated START; the clock stays still outside frames.
  task automatic start();
    sda_lo = 1'b0;
    #40 scl_lo = 1'b0;
    #100 sda_lo = 1'b1;
    #100 scl_lo = 1'b1;
    #200;
  endtask
  // Sends MSB first and waits while the slave holds the clock low.
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      #10 sda_lo = (i > 0) ? ~b[i-1] : 1'b0;
      #30 scl_lo = 1'b0;
      wait (scl);
      ack = ~sda;
      #40 scl_lo = 1'b1;
    end
  endtask
  task automatic stop();
    #10 sda_lo = 1'b1;
    #30 scl_lo = 1'b0;
    #40 sda_lo = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// [sspsl_slave_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker.
// ----------------------------------------
module sspsl_slave_chk
  import sspsl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic ten_bit_mode,
  input wire logic int_enable,
  input wire logic addr_wr,
  input wire logic [7:0] addr_wdata,
  input wire logic [7:0] own_address_register,
  input wire logic if_clear,
  input wire logic ov_clear,
  input wire sspsl_stat_t status,
  input wire logic irq,
  input wire logic rx_valid,
  input wire logic rx_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_irq_gate: assert property (irq == (status.pif && int_enable)) else $error("irq mismatch");
  a_addr_write: assert property (addr_wr |=> own_address_register == $past(addr_wdata) && !status.ua)
    else $error("own address write lost");
  a_pop_bf: assert property (rx_valid && rx_ready |=> !status.bf) else $error("pop kept full");
  a_pif_hold: assert property ($fell(status.pif) |-> $past(if_clear)) else $error("flag dropped");
  a_ov_hold: assert property ($fell(status.ov) |-> $past(ov_clear)) else $error("overflow dropped");
  a_bf_load: assert property ($rose(status.bf) |-> rx_valid && !status.rw) else $error("full, no data");
  a_ack_flags: assert property ($rose(sda_oe) |-> !status.bf && !status.ov) else $error("ack when full");
  a_ua_hold: assert property ($rose(status.ua) |-> ten_bit_mode ##[1:40] scl_oe) else $error("no hold");
  c_ua: cover property ($rose(status.ua));
  c_ov: cover property ($rose(status.ov));
  c_release: cover property ($fell(scl_oe));
endmodule
bind sspsl_slave sspsl_slave_chk sspsl_slave_chk_inst (.clk, .reset_n, .scl_oe, .sda_oe, .ten_bit_mode,
  .int_enable, .addr_wr, .addr_wdata, .own_address_register, .if_clear, .ov_clear, .status, .irq, .rx_valid,
  .rx_ready);
`default_nettype wire

// [sspsl_slave_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sspsl_slave_bench
  import sspsl_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ten_bit_mode = 1'b0, int_enable = 1'b1, addr_wr = 1'b0, if_clear = 1'b0, ov_clear = 1'b0;
  logic rx_ready = 1'b0;
  logic port_enable = 1'b1;
  logic [7:0] addr_wdata = 8'h00;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, rx_valid, m_scl_lo, m_sda_lo, ack;
  logic [7:0] own_address_register, rx_data;
  sspsl_stat_t status;
  int fail_count = 0, checks_done = 0;
  // Open-drain lines with pull-ups.
  wire logic scl = ~(m_scl_lo | scl_oe);
  wire logic sda = ~(m_sda_lo | sda_oe);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  sspsl_slave sspsl_slave_inst (.clk, .reset_n, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
    .port_enable, .ten_bit_mode, .int_enable, .addr_wr, .addr_wdata, .own_address_register, .if_clear,
    .ov_clear, .status, .irq, .rx_data, .rx_valid, .rx_ready);
  sspsl_master sspsl_master_inst (.scl, .sda, .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));
  // ----------------------------------------
  // Access tasks.
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [4:0] e);
    chk({3'h0, status}, {3'h0, e});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic own(input logic [7:0] v);
    @(negedge clk) addr_wdata = v;
    pulse(addr_wr);
    @(negedge clk);
    chk(own_address_register, v);
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    sspsl_master_inst.send(b, ack);
    chk({7'h00, ack}, {7'h00, exp_ack});
    repeat (8) @(negedge clk);
  endtask
  task automatic done_byte();
    pulse(rx_ready);
    pulse(if_clear);
  endtask
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end
  // ----------------------------------------
  // Tests.
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    st(5'h00);
    chk(own_address_register, 8'h00);
    chk({6'h00, scl_o, sda_o}, 8'h00);
    own(8'ha4);
    @(negedge clk) port_enable = 1'b0;
    sspsl_master_inst.start();
    xfer(8'ha4, 1'b0);
    st(5'h00);
    sspsl_master_inst.stop();
    @(negedge clk) port_enable = 1'b1;
    sspsl_master_inst.start();
    xfer(8'ha4, 1'b1);
    st(5'h11);
    chk(rx_data, 8'ha4);
    chk({7'h00, irq}, 8'h01);
    xfer(8'h3c, 1'b0);
    st(5'h19);
    pulse(rx_ready);
    chk({7'h00, rx_valid}, 8'h00);
    st(5'h09);
    xfer(8'h5a, 1'b0);
    chk(rx_data, 8'h5a);
    pulse(ov_clear);
    done_byte();
    st(5'h00);
    xfer(8'h77, 1'b1);
    st(5'h11);
    done_byte();
    sspsl_master_inst.stop();
    sspsl_master_inst.start();
    xfer(8'h10, 1'b0);
    xfer(8'ha4, 1'b0);
    st(5'h00);
    chk({7'h00, rx_valid}, 8'h00);
    sspsl_master_inst.stop();
    @(negedge clk) ten_bit_mode = 1'b1;
    own(8'hf2);
    sspsl_master_inst.start();
    xfer(8'hf2, 1'b1);
    st(5'h15);
    chk({7'h00, scl_oe}, 8'h01);
    done_byte();
    own(8'h35);
    chk({7'h00, scl_oe}, 8'h00);
    st(5'h00);
    xfer(8'h35, 1'b1);
    st(5'h15);
    done_byte();
    own(8'hf2);
    xfer(8'h11, 1'b1);
    chk(rx_data, 8'h11);
    done_byte();
    sspsl_master_inst.start();
    xfer(8'hf2, 1'b1);
    st(5'h11);
    @(negedge clk) int_enable = 1'b0;
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    sspsl_master_inst.stop();
    end_sim();
  end
endmodule
`default_nettype wire
